// >>> sktpw_card_model.sv
// sktpw_card_model.sv
// inserted card, seen only through its voltage key pins
// assumes the bench picks which supply voltages the card accepts
`timescale 1ns/100ps
module sktpw_card_model (
  input wire logic sys_clk,
  input wire logic [3:0] card_kind,
  output logic card_5v_sense,
  output logic card_3v_sense,
  output logic card_xv_sense,
  output logic card_yv_sense
);
  // ----------------------------------------------------------------
  // key pins
  // ----------------------------------------------------------------
  logic [3:0] key_ff;
  // keys settle a clock after a swap, as a real insertion would
  always_ff @(posedge sys_clk) begin
    key_ff <= card_kind;
  end
  assign card_5v_sense = key_ff[0];
  assign card_3v_sense = key_ff[1];
  assign card_xv_sense = key_ff[2];
  assign card_yv_sense = key_ff[3];
endmodule

// >>> sktpw_clk_stop.sv
// sktpw_clk_stop.sv
// card clock stop decision: idle count then policy gate
// assumes socket_idle and pci_stop_prep are synchronous to sys_clk
`timescale 1ns/100ps
`include "sktpw_params.svh"
module sktpw_clk_stop (
  input wire logic sys_clk,
  input wire logic rst_b,
  sktpw_stop_if.stopper stp
);
  import sktpw_pkg::*;

  sktpw_stop_state_e state_ff;
  sktpw_stop_state_e nxt_state;
  logic [3:0] idle_cnt_ff;
  logic [3:0] nxt_idle_cnt;
  wire logic idle_done;
  wire logic stop_allowed;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // any socket activity restarts the idle count
  assign idle_done = (idle_cnt_ff == (`SKTPW_IDLE_CLOCKS - 4'h1));
  // policy 1 ignores the pci clock-run state
  assign stop_allowed = stp.policy | stp.pci_stop_prep;
  assign stp.stop_req = (state_ff == SKTPW_STOP);
  assign stp.counting = (state_ff == SKTPW_COUNT);

  // next state and idle counter
  always_comb begin
    nxt_state = state_ff;
    nxt_idle_cnt = idle_cnt_ff;
    case (state_ff)
      SKTPW_RUN: begin
        nxt_idle_cnt = 4'h0;
        if (stp.socket_idle) begin
          nxt_state = SKTPW_COUNT;
        end
      end
      SKTPW_COUNT: begin
        if (!stp.socket_idle) begin
          nxt_state = SKTPW_RUN;
        end else if (!idle_done) begin
          nxt_idle_cnt = idle_cnt_ff + 4'h1;
        end else if (stop_allowed) begin
          nxt_state = SKTPW_STOP;
        end
      end
      SKTPW_STOP: begin
        // leave at once when either condition goes away
        if (!stp.socket_idle || !stop_allowed) begin
          nxt_state = SKTPW_RUN;
        end
      end
      default: begin
        nxt_state = SKTPW_RUN;
      end
    endcase
  end

  // state registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= SKTPW_RUN;
      idle_cnt_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      idle_cnt_ff <= nxt_idle_cnt;
    end
  end
endmodule

// >>> sktpw_ctrl.sv
// sktpw_ctrl.sv
// socket supply control register bank with wishbone classic slave
// assumes synchronous pin inputs, the card type sense pins come from card interrogation
`timescale 1ns/100ps
`include "sktpw_params.svh"
module sktpw_ctrl (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic global_reset_pin,
  input wire logic bus_reset_pin,
  input wire logic pme_enable,
  input wire logic card_5v_sense,
  input wire logic card_3v_sense,
  input wire logic card_xv_sense,
  input wire logic card_yv_sense,
  input wire logic socket_idle,
  input wire logic pci_clk_stop_prep,
  output logic card_clk_stop_req,
  output sktpw_pkg::sktpw_code_t core_supply_apply,
  output sktpw_pkg::sktpw_code_t program_supply_apply,
  output logic socket_powered_status
);
  import sktpw_pkg::*;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // a code passes only if the card accepts that voltage, 12v only when allow_12v is set, else off
  function automatic sktpw_code_t supply_gate(input sktpw_code_t code, input logic [3:0] ok,
                                              input logic allow_12v);
    sktpw_code_t res;
    res = `SKTPW_CODE_OFF;
    case (code)
      `SKTPW_CODE_12V: res = allow_12v ? code : `SKTPW_CODE_OFF;
      `SKTPW_CODE_5V: res = ok[0] ? code : `SKTPW_CODE_OFF;
      `SKTPW_CODE_3V3: res = ok[1] ? code : `SKTPW_CODE_OFF;
      `SKTPW_CODE_XV: res = ok[2] ? code : `SKTPW_CODE_OFF;
      `SKTPW_CODE_YV: res = ok[3] ? code : `SKTPW_CODE_OFF;
      default: res = `SKTPW_CODE_OFF;
    endcase
    return res;
  endfunction

  // merge byte-enabled write data into a stored word
  function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] wr,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic policy_ff;
  sktpw_code_t core_req_ff;
  sktpw_code_t prog_req_ff;
  logic [3:0] type_ok_ff;
  logic auto_en_ff;
  sktpw_code_t core_apply_ff;
  sktpw_code_t prog_apply_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic nxt_policy;
  sktpw_code_t nxt_core_req;
  sktpw_code_t nxt_prog_req;
  logic [3:0] nxt_type_ok;
  logic nxt_auto_en;

  sktpw_stop_if stop_bus ();

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic bus_req;
  wire logic hit_supply;
  wire logic hit_type;
  wire logic wr_take;
  wire logic wr_supply;
  wire logic wr_type;
  wire logic [31:0] supply_word;
  wire logic [31:0] type_word;
  wire logic [31:0] supply_merged;
  wire logic [31:0] type_merged;
  wire logic [31:0] read_sel;
  wire logic field_clear;

  // requests are answered one cycle late, write commits on the ack edge
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign hit_supply = (wb_adr_i == `SKTPW_ADR_SUPPLY_CTRL);
  assign hit_type = (wb_adr_i == `SKTPW_ADR_TYPE_CTRL);
  assign wr_take = bus_req & wb_we_i & ack_ff;
  assign wr_supply = wr_take & hit_supply;
  assign wr_type = wr_take & hit_type;

  // supply control read word: fixed bits and writable fields only
  assign supply_word = {21'h0, 1'b1, 2'h0, policy_ff, core_req_ff, 1'b0, prog_req_ff};
  // type control read word: sensed types, auto state and applied codes
  assign type_word = {17'h0, prog_apply_ff, 1'b0, core_apply_ff, 2'h0, socket_powered_status,
                      auto_en_ff, type_ok_ff};
  assign supply_merged = byte_merge(supply_word, wb_dat_i, wb_sel_i);
  assign type_merged = byte_merge(32'h0, wb_dat_i, wb_sel_i);
  // unmapped addresses read zero and are still acknowledged
  assign read_sel = hit_supply ? supply_word : (hit_type ? type_word : 32'h0);

  // ----------------------------------------------------------------
  // reset scope of the supply fields
  // ----------------------------------------------------------------
  // with pme enabled only the global reset clears them
  assign field_clear = global_reset_pin | (bus_reset_pin & ~pme_enable);

  // ----------------------------------------------------------------
  // next values of software-visible state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_policy = policy_ff;
    nxt_core_req = core_req_ff;
    nxt_prog_req = prog_req_ff;
    nxt_type_ok = type_ok_ff;
    nxt_auto_en = auto_en_ff;
    // from the supply word only policy and the two supply fields take write data
    if (wr_supply) begin
      nxt_policy = supply_merged[`SKTPW_POLICY_BIT];
      nxt_core_req = supply_merged[`SKTPW_CORE_HI:`SKTPW_CORE_LO];
      nxt_prog_req = supply_merged[`SKTPW_PROG_HI:`SKTPW_PROG_LO];
    end
    // retest wins over a force in the same write
    if (wr_type) begin
      if (type_merged[`SKTPW_RETEST_BIT]) begin
        nxt_type_ok = {card_yv_sense, card_xv_sense, card_3v_sense, card_5v_sense};
        nxt_auto_en = 1'b1;
      end else if (type_merged[`SKTPW_FORCE5_BIT] | type_merged[`SKTPW_FORCE3_BIT]) begin
        nxt_type_ok[0] = type_merged[`SKTPW_FORCE5_BIT];
        nxt_type_ok[1] = type_merged[`SKTPW_FORCE3_BIT];
        nxt_auto_en = 1'b0;
      end
    end
    // bus-reset class fields: policy has no pme context so it follows both resets
    if (global_reset_pin | bus_reset_pin) begin
      nxt_policy = `SKTPW_POLICY_RESET;
    end
    if (field_clear) begin
      nxt_core_req = `SKTPW_SUPPLY_RESET;
      nxt_prog_req = `SKTPW_SUPPLY_RESET;
    end
  end

  // software-visible registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      policy_ff <= `SKTPW_POLICY_RESET;
      core_req_ff <= `SKTPW_SUPPLY_RESET;
      prog_req_ff <= `SKTPW_SUPPLY_RESET;
      type_ok_ff <= 4'h0;
      auto_en_ff <= 1'b1;
    end else begin
      policy_ff <= nxt_policy;
      core_req_ff <= nxt_core_req;
      prog_req_ff <= nxt_prog_req;
      type_ok_ff <= nxt_type_ok;
      auto_en_ff <= nxt_auto_en;
    end
  end

  // ----------------------------------------------------------------
  // applied supplies
  // ----------------------------------------------------------------
  // frozen while auto control is off so a forced type cannot glitch the rails
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_apply_ff <= `SKTPW_CODE_OFF;
      prog_apply_ff <= `SKTPW_CODE_OFF;
    end else if (auto_en_ff) begin
      core_apply_ff <= supply_gate(core_req_ff, type_ok_ff, 1'b0);
      prog_apply_ff <= supply_gate(prog_req_ff, type_ok_ff, |type_ok_ff);
    end
  end

  assign core_supply_apply = core_apply_ff;
  assign program_supply_apply = prog_apply_ff;
  // powered means the applied core rail code is not off
  assign socket_powered_status = (core_apply_ff != `SKTPW_CODE_OFF);

  // ----------------------------------------------------------------
  // wishbone answer
  // ----------------------------------------------------------------
  // ack for one cycle, data captured with it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
      rdat_ff <= (bus_req & ~ack_ff & ~wb_we_i) ? read_sel : 32'h0;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // ----------------------------------------------------------------
  // card clock stop
  // ----------------------------------------------------------------
  assign stop_bus.policy = policy_ff;
  assign stop_bus.socket_idle = socket_idle;
  assign stop_bus.pci_stop_prep = pci_clk_stop_prep;
  assign card_clk_stop_req = stop_bus.stop_req;

  sktpw_clk_stop u_clk_stop (
    .sys_clk (sys_clk),
    .rst_b (rst_b),
    .stp (stop_bus)
  );
endmodule

// >>> sktpw_ctrl_props.sv
// sktpw_ctrl_props.sv
// port-level checks of the socket supply block
// assumes it is bound into sktpw_ctrl, one clock domain
`timescale 1ns/100ps
`include "sktpw_params.svh"
module sktpw_ctrl_props (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic socket_idle,
  input wire logic card_clk_stop_req,
  input wire sktpw_pkg::sktpw_code_t core_supply_apply,
  input wire sktpw_pkg::sktpw_code_t program_supply_apply,
  input wire logic socket_powered_status
);
  import sktpw_pkg::*;
  // ----------------------------------------------------------------
  // idle run length
  // ----------------------------------------------------------------
  logic [3:0] idle_run_ff;
  logic [3:0] nxt_idle_run;
  // saturates so a long idle spell never wraps back under 8
  assign nxt_idle_run = !socket_idle ? 4'h0 : (idle_run_ff == 4'hF) ? idle_run_ff : idle_run_ff + 4'h1;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_run_ff <= 4'h0;
    end else begin
      idle_run_ff <= nxt_idle_run;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("late ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  a_fixed_bits: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == `SKTPW_ADR_SUPPLY_CTRL |-> (wb_dat_o & 32'hFFFFFB08) == 32'h0 && wb_dat_o[10])
    else $error("fixed bits wrong");
  a_stop_idle: assert property ($rose(card_clk_stop_req) |-> idle_run_ff >= 4'h8)
    else $error("stop before 8 idle clocks");
  a_stop_drop: assert property (
    card_clk_stop_req && !socket_idle |-> ##[1:2] !card_clk_stop_req) else $error("stop held while busy");
  a_core_legal: assert property (core_supply_apply inside {3'h0, [3'h2:3'h5]})
    else $error("reserved core code applied");
  a_prog_legal: assert property (program_supply_apply inside {[3'h0:3'h5]})
    else $error("reserved program code applied");
  a_power_core: assert property (socket_powered_status == (core_supply_apply != 3'h0))
    else $error("powered status wrong");
  a_apply_reset: assert property (
    $rose(rst_b) |-> core_supply_apply == 3'h0 && program_supply_apply == 3'h0 && !socket_powered_status)
    else $error("supply on after reset");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_stop: cover property ($rose(card_clk_stop_req));
  c_core3: cover property (core_supply_apply == `SKTPW_CODE_3V3);
endmodule

bind sktpw_ctrl sktpw_ctrl_props sktpw_ctrl_props_i (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .socket_idle(socket_idle), .card_clk_stop_req(card_clk_stop_req), .core_supply_apply(core_supply_apply),
  .program_supply_apply(program_supply_apply), .socket_powered_status(socket_powered_status));

// >>> sktpw_params.svh
// sktpw_params.svh
// offsets, field positions, reset values and timing counts of the socket supply block
// assumes a byte-addressed wishbone window with one 32-bit word per register
`ifndef SKTPW_PARAMS_SVH
`define SKTPW_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SKTPW_ADR_SUPPLY_CTRL 8'h10
`define SKTPW_ADR_TYPE_CTRL 8'h14

// ----------------------------------------------------------------
// supply control field layout
// ----------------------------------------------------------------
`define SKTPW_POLICY_BIT 7
`define SKTPW_CORE_HI 6
`define SKTPW_CORE_LO 4
`define SKTPW_PROG_HI 2
`define SKTPW_PROG_LO 0
`define SKTPW_FIXED_ONE_BIT 10
`define SKTPW_SUPPLY_RESET 3'h0
`define SKTPW_POLICY_RESET 1'h0

// ----------------------------------------------------------------
// type control field layout (write side / read side)
// ----------------------------------------------------------------
`define SKTPW_FORCE5_BIT 0
`define SKTPW_FORCE3_BIT 1
`define SKTPW_RETEST_BIT 2
`define SKTPW_TYPE_XV_BIT 2
`define SKTPW_TYPE_YV_BIT 3
`define SKTPW_AUTO_EN_BIT 4
`define SKTPW_POWERED_BIT 5
`define SKTPW_CORE_OUT_LO 8
`define SKTPW_PROG_OUT_LO 12

// ----------------------------------------------------------------
// supply codes
// ----------------------------------------------------------------
`define SKTPW_CODE_OFF 3'h0
`define SKTPW_CODE_12V 3'h1
`define SKTPW_CODE_5V 3'h2
`define SKTPW_CODE_3V3 3'h3
`define SKTPW_CODE_XV 3'h4
`define SKTPW_CODE_YV 3'h5

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SKTPW_IDLE_CLOCKS 4'h8

`endif

// >>> sktpw_pkg.sv
// sktpw_pkg.sv
// types shared by the socket supply block
// assumes the constants of sktpw_params.svh
package sktpw_pkg;

  typedef logic [2:0] sktpw_code_t;

  typedef enum logic [1:0] {
    SKTPW_RUN,
    SKTPW_COUNT,
    SKTPW_STOP
  } sktpw_stop_state_e;

endpackage

// >>> sktpw_stop_if.sv
// sktpw_stop_if.sv
// carrier between the register bank and the card clock stop logic
// assumes both ends run on sys_clk
`timescale 1ns/100ps
interface sktpw_stop_if;
  logic policy;
  logic socket_idle;
  logic pci_stop_prep;
  logic stop_req;
  logic counting;

  modport ctrl (output policy, output socket_idle, output pci_stop_prep, input stop_req, input counting);
  modport stopper (input policy, input socket_idle, input pci_stop_prep, output stop_req, output counting);
endinterface

// >>> tb_socket_supply_control.sv
// tb_socket_supply_control.sv
// self-checking bench for the socket supply register bank
// assumes sktpw_ctrl, its checker and the card model compile first
`timescale 1ns/100ps
`include "sktpw_params.svh"
module tb_socket_supply_control;
  import sktpw_pkg::*;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic global_reset_pin = 1'b0;
  logic bus_reset_pin = 1'b0;
  logic pme_enable = 1'b0;
  logic [3:0] card_kind = 4'h0;
  logic socket_idle = 1'b0;
  logic pci_clk_stop_prep = 1'b0;
  logic [31:0] wb_dat_o;
  logic [31:0] rd_q;
  logic [3:0] sel_q = 4'hF;
  logic wb_ack_o, card_clk_stop_req, socket_powered_status, c5, c3, cx, cy;
  sktpw_code_t core_supply_apply;
  sktpw_code_t program_supply_apply;
  int miscompares = 0;
  int check_count = 0;
  sktpw_card_model sktpw_card_model_i (.sys_clk(sys_clk), .card_kind(card_kind), .card_5v_sense(c5),
    .card_3v_sense(c3), .card_xv_sense(cx), .card_yv_sense(cy));
  sktpw_ctrl sktpw_ctrl_i (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .global_reset_pin(global_reset_pin), .bus_reset_pin(bus_reset_pin),
    .pme_enable(pme_enable), .card_5v_sense(c5), .card_3v_sense(c3), .card_xv_sense(cx), .card_yv_sense(cy),
    .socket_idle(socket_idle), .pci_clk_stop_prep(pci_clk_stop_prep), .card_clk_stop_req(card_clk_stop_req),
    .core_supply_apply(core_supply_apply), .program_supply_apply(program_supply_apply),
    .socket_powered_status(socket_powered_status));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // one classic cycle; ack is sampled at the edge, never assumed
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sel_q;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd_q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd_q & m, e);
  endtask
  task automatic pulse(input logic g);
    @(posedge sys_clk);
    global_reset_pin <= g;
    bus_reset_pin <= !g;
    @(posedge sys_clk);
    global_reset_pin <= 1'b0;
    bus_reset_pin <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_fields;
    rd(`SKTPW_ADR_SUPPLY_CTRL, '1, 32'h400);
    chk(core_supply_apply | program_supply_apply, 3'h0);
    wr(`SKTPW_ADR_SUPPLY_CTRL, 32'hFFFFFFFF);
    rd(`SKTPW_ADR_SUPPLY_CTRL, '1, 32'h4F7);
    // byte 0 disabled: the writable fields must keep their value
    sel_q = 4'hE;
    wr(`SKTPW_ADR_SUPPLY_CTRL, 32'h0);
    sel_q = 4'hF;
    rd(`SKTPW_ADR_SUPPLY_CTRL, '1, 32'h4F7);
    wr(`SKTPW_ADR_SUPPLY_CTRL, 32'h0);
    rd(`SKTPW_ADR_SUPPLY_CTRL, '1, 32'h400);
    rd(8'h40, '1, 32'h0);
  endtask
  // every code on both supplies, for cards of several key sets
  task automatic t_codes;
    logic [3:0] kinds [3] = '{4'h2, 4'hF, 4'h1};
    logic [2:0] e;
    for (int k = 0; k < 3; k++) begin
      card_kind <= kinds[k];
      tick(2);
      wr(`SKTPW_ADR_TYPE_CTRL, 32'h4);
      rd(`SKTPW_ADR_TYPE_CTRL, 32'hFFFF, {28'h1, kinds[k]});
      for (int c = 0; c < 8; c++) begin
        wr(`SKTPW_ADR_SUPPLY_CTRL, 32'(c * 17));
        tick(3);
        e = (c >= 2 && c <= 5 && kinds[k][c-2]) ? 3'(c) : 3'h0;
        chk(core_supply_apply, e);
        chk(program_supply_apply, (c == 1) ? 3'h1 : e);
        chk(socket_powered_status, e != 3'h0);
      end
      wr(`SKTPW_ADR_SUPPLY_CTRL, 32'h0);
    end
  endtask
  // card keyed 5v only; forcing a 3v type must freeze the rails, retest re-senses
  task automatic t_force;
    wr(`SKTPW_ADR_SUPPLY_CTRL, 32'h22);
    tick(3);
    chk(core_supply_apply, 3'h2);
    wr(`SKTPW_ADR_TYPE_CTRL, 32'h2);
    wr(`SKTPW_ADR_SUPPLY_CTRL, 32'h33);
    tick(3);
    rd(`SKTPW_ADR_TYPE_CTRL, 32'h1F, 32'h02);
    chk(core_supply_apply, 3'h2);
    wr(`SKTPW_ADR_TYPE_CTRL, 32'h4);
    tick(3);
    rd(`SKTPW_ADR_TYPE_CTRL, 32'h1F, 32'h11);
    chk(core_supply_apply, 3'h0);
  endtask
  task automatic t_pins;
    pme_enable <= 1'b1;
    wr(`SKTPW_ADR_SUPPLY_CTRL, 32'hB3);
    pulse(1'b0);
    rd(`SKTPW_ADR_SUPPLY_CTRL, '1, 32'h433);
    pulse(1'b1);
    rd(`SKTPW_ADR_SUPPLY_CTRL, '1, 32'h400);
    pme_enable <= 1'b0;
    wr(`SKTPW_ADR_SUPPLY_CTRL, 32'h33);
    pulse(1'b0);
    rd(`SKTPW_ADR_SUPPLY_CTRL, '1, 32'h400);
  endtask
  task automatic wait_stop(output int n);
    n = 0;
    while (card_clk_stop_req !== 1'b1 && n < 16) begin
      @(posedge sys_clk);
      n++;
    end
    // a stop that never comes ends the run as a mismatch
    if (card_clk_stop_req !== 1'b1) begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic t_stop;
    int n;
    wr(`SKTPW_ADR_SUPPLY_CTRL, 32'h80);
    socket_idle <= 1'b1;
    wait_stop(n);
    chk(n >= 9 && n <= 12, 1'b1);
    socket_idle <= 1'b0;
    tick(3);
    chk(card_clk_stop_req, 1'b0);
    wr(`SKTPW_ADR_SUPPLY_CTRL, 32'h0);
    socket_idle <= 1'b1;
    tick(14);
    chk(card_clk_stop_req, 1'b0);
    pci_clk_stop_prep <= 1'b1;
    wait_stop(n);
    chk(n <= 3, 1'b1);
    socket_idle <= 1'b0;
    pci_clk_stop_prep <= 1'b0;
    tick(3);
  endtask
  // ----------------------------------------------------------------
  // clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    tick(8);
    rst_b <= 1'b1;
    t_fields();
    t_codes();
    t_force();
    t_pins();
    t_stop();
    final_report();
  end
endmodule
